// ### core/hcp_pkg.sv
// hcp_pkg: constants and types shared by the host cpu port block.
// assumes: a single core clock domain, word-addressed 16-bit host bus.
package hcp_pkg;

   // register offsets on the ahb-lite slave (byte addresses)
   localparam logic [7:0] REG_VERSION = 8'h00;
   localparam logic [7:0] REG_MAIN_STATUS = 8'h04;
   localparam logic [7:0] REG_MAIN_MASK = 8'h08;
   localparam logic [7:0] REG_TIMER_STATUS = 8'h0c;
   localparam logic [7:0] REG_TIMER_MASK = 8'h10;
   localparam logic [7:0] REG_CACHES = 8'h14;

   // register word indices on the host port, below the ram window
   localparam logic [2:0] HREG_VERSION = 3'h0;
   localparam logic [2:0] HREG_MAIN_STATUS = 3'h1;
   localparam logic [2:0] HREG_MAIN_MASK = 3'h2;
   localparam logic [2:0] HREG_TIMER_STATUS = 3'h3;
   localparam logic [2:0] HREG_TIMER_MASK = 3'h4;

   // first host word address of the ram window
   localparam logic [17:0] RAM_BASE = 18'h00200;

   // version register layout
   localparam int unsigned VER_MODE_POS = 8;

   // bus personality codes
   localparam logic STYLE_SPLIT = 1'h0;
   localparam logic STYLE_RW = 1'h1;

   // reset values of the mask registers (1 = source masked)
   localparam logic [7:0] MAIN_MASK_RST = 8'hff;
   localparam logic [7:0] TIMER_MASK_RST = 8'h00;

   // wait states a host without the handshake must insert
   localparam int unsigned HOST_WAIT_STATES = 23;

   typedef enum logic [2:0] {
      HCP_IDLE = 3'b001,
      HCP_RD_WAIT = 3'b010,
      HCP_ACK = 3'b100
   } hcp_state_t;

endpackage : hcp_pkg

// ### core/hcp_irq_if.sv
// hcp_irq_if: events, clears and mask writes into one interrupt bank, and its state back.
// assumes: driven from the core clock domain only.
`timescale 1ns/1ps
interface hcp_irq_if #(parameter int unsigned W = 8);
   logic [W-1:0] event_v;
   logic [W-1:0] clr_v;
   logic mask_we;
   logic [W-1:0] mask_wdata;
   logic [W-1:0] status;
   logic [W-1:0] mask;
   logic irq;

   modport ctl (
      output event_v,
      output clr_v,
      output mask_we,
      output mask_wdata,
      input status,
      input mask,
      input irq
   );

   modport bank (
      input event_v,
      input clr_v,
      input mask_we,
      input mask_wdata,
      output status,
      output mask,
      output irq
   );
endinterface : hcp_irq_if

// ### core/hcp_irq.sv
// hcp_irq: one bank of sticky status bits, a mask and a registered level interrupt.
// assumes: clr_v and mask_we are one-cycle strobes from the register slave.
`timescale 1ns/1ps
module hcp_irq #(
   parameter int unsigned W = 8,
   parameter logic [W-1:0] MASK_RST = '0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bank signals
   hcp_irq_if.bank b
);
   logic [W-1:0] status_q;
   logic [W-1:0] status_d;
   logic [W-1:0] mask_q;
   logic irq_q;

   // a set in the same cycle as its clear survives
   assign status_d = (status_q & ~b.clr_v) | b.event_v;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         status_q <= '0;
      else
         status_q <= status_d;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         mask_q <= MASK_RST;
      else if (b.mask_we)
         mask_q <= b.mask_wdata;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         irq_q <= 1'h0;
      else
         irq_q <= |(status_q & ~mask_q); // see [RL11]
   end

   assign b.status = status_q;
   assign b.mask = mask_q;
   assign b.irq = irq_q;

   a_event_sticks: // see [RL12]
   assert property (@(posedge clk_i) disable iff (rst_i)
      (b.event_v != '0) |=> ((status_q & $past(b.event_v)) == $past(b.event_v)))
   else $error("event did not set its status bit");

   a_masked_quiet: // see [RL11]
   assert property (@(posedge clk_i) disable iff (rst_i)
      ((status_q & ~mask_q) == '0) |=> !irq_q)
   else $error("interrupt raised with all set sources masked");

   a_unmasked_fires: // see [RL12]
   assert property (@(posedge clk_i) disable iff (rst_i)
      ((status_q & ~mask_q) != '0) |=> irq_q)
   else $error("unmasked status bit did not raise interrupt");
endmodule : hcp_irq

// ### core/hcp_ram.sv
// hcp_ram: single-port word memory behind the host port, registered read data.
// assumes: re and we are never high together; contents are not reset.
`timescale 1ns/1ps
module hcp_ram #(
   parameter int unsigned DW = 32,
   parameter int unsigned AW = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // access port
   input wire logic re_i,
   input wire logic we_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [DW-1:0] wdata_i,
   output logic [DW-1:0] rdata_o
);
   logic [DW-1:0] mem [0:(1<<AW)-1];
   logic [DW-1:0] rdata_q;

   always_ff @(posedge clk_i)
   begin
      if (we_i)
         mem[addr_i] <= wdata_i;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         rdata_q <= '0;
      else if (re_i)
         rdata_q <= mem[addr_i];
   end

   assign rdata_o = rdata_q;
endmodule : hcp_ram

// ### core/hcp_top.sv
// hcp_top: 16-bit host cpu port with split ram access, strapped bus style and two interrupts.
// assumes: host pins and events synchronous to CORE_CLK_I; one ahb-lite master for software.
//
// Contract
// [RL1] every register access is one 16-bit transfer; host addresses count 16-bit words
// [RL2] host does 32-bit ram access as low half (bit0=0) then high half (bit0=1)
// [RL3] upper address bits of the two halves are never compared
// [RL4] low-half write fills write cache; high-half write commits {bus, cache}
// [RL5] low-half read fetches whole word, returns low half, caches high half
// [RL6] high-half read returns the read cache without touching ram
// [RL7] host may skip the high-half read when it needs only the low half
// [RL8] data bus is little-endian; big-endian hosts swap lanes themselves
// [RL9] hosts ignoring the acknowledge insert 23 wait states per access
// [RL10] two separate interrupt outputs: main bank and timer bank
// [RL11] each main source has a mask bit; masked sources never raise main interrupt
// [RL12] any expiring timer sets its status bit and raises the auxiliary interrupt; here only while its REG_TIMER_MASK bit is 0
// [RL13] straps sampled at reset release: both low split style, both high r/w style
// [RL14] board holds straps stable at least three clocks after reset release
// [RL15] version register shows the selected bus style, read-only
// [RL16] split-style glue turns each acknowledge rising edge into one ready pulse
// [RL17] interrupt software reads status registers to find the causes
// [RL18] mixed strap levels are reserved and fall back to split style
// [RL19] a repeated low-half write just overwrites the write cache
`timescale 1ns/1ps
module hcp_top #(
   parameter int unsigned RAM_AW = 8,
   parameter logic [7:0] REV_CODE = 8'h5a // arbitrary revision code
) (
   // clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RESET_I,
   // ahb-lite register slave
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   // host port
   input wire logic [17:0] HOST_WORD_ADDR_I,
   input wire logic [15:0] HOST_DATA_BUS_I,
   output logic [15:0] HOST_DATA_BUS_O,
   output logic HOST_DATA_BUS_OE_O,
   input wire logic HOST_CS_N_I,
   input wire logic HOST_RD_N_I,
   input wire logic HOST_WR_N_I,
   output logic HOST_ACCESS_ACK_O,
   // bus style straps
   input wire logic BUS_STYLE_STRAP_A_I,
   input wire logic BUS_STYLE_STRAP_B_I,
   // interrupt sources and outputs
   input wire logic [7:0] MAIN_EVENT_I,
   input wire logic [7:0] TIMER_EXPIRE_I,
   output logic MAIN_IRQ_OUT_O,
   output logic AUX_IRQ_OUT_O
);
   localparam int ACK_MAX_CYC = 3;

   logic strap_done_q;
   logic mode_q;
   hcp_pkg::hcp_state_t state_q;
   hcp_pkg::hcp_state_t state_d;
   logic host_strobe;
   logic host_read;
   logic host_active;
   logic host_ram;
   logic host_hi;
   logic start;
   logic rd_q;
   logic [15:0] wr_cache_q;
   logic [15:0] rd_cache_q;
   logic [15:0] data_o_q;
   logic oe_q;
   logic ack_q;
   logic [15:0] host_reg16;
   logic ram_re;
   logic ram_we;
   logic [RAM_AW-1:0] ram_addr;
   logic [31:0] ram_wdata;
   logic [31:0] ram_rdata;
   logic ahb_valid;
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic [31:0] hrdata_q;
   logic hreadyout_q;
   logic hresp_q;
   logic [31:0] ahb_rd_mux;
   logic [31:0] version_word;

   hcp_irq_if #(.W(8)) main_if ();
   hcp_irq_if #(.W(8)) timer_if ();

   // straps are caught by the first clock after release, never by the reset itself
   always_ff @(posedge CORE_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         strap_done_q <= 1'h0;
         mode_q <= hcp_pkg::STYLE_SPLIT;
      end
      else if (!strap_done_q)
      begin
         strap_done_q <= 1'h1;
         if (BUS_STYLE_STRAP_A_I && BUS_STYLE_STRAP_B_I) // see [RL13]
            mode_q <= hcp_pkg::STYLE_RW;
         else
            mode_q <= hcp_pkg::STYLE_SPLIT; // see [RL13] [RL18]
      end
   end

   // in r/w style the read strobe pin is the r/w line and the write pin the data strobe
   always_comb
   begin
      if (mode_q == hcp_pkg::STYLE_SPLIT)
      begin
         host_strobe = !HOST_RD_N_I || !HOST_WR_N_I;
         host_read = !HOST_RD_N_I;
      end
      else
      begin
         host_strobe = !HOST_WR_N_I;
         host_read = HOST_RD_N_I;
      end
   end

   // accesses before the straps are caught are held off
   assign host_active = !HOST_CS_N_I && host_strobe && strap_done_q;
   assign host_ram = HOST_WORD_ADDR_I >= hcp_pkg::RAM_BASE;
   assign host_hi = HOST_WORD_ADDR_I[0];
   assign start = (state_q == hcp_pkg::HCP_IDLE) && host_active;

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         hcp_pkg::HCP_IDLE:
         begin
            if (host_active)
            begin
               if (host_read && host_ram && !host_hi)
                  state_d = hcp_pkg::HCP_RD_WAIT;
               else
                  state_d = hcp_pkg::HCP_ACK;
            end
         end
         hcp_pkg::HCP_RD_WAIT:
            state_d = hcp_pkg::HCP_ACK;
         hcp_pkg::HCP_ACK:
         begin
            if (!host_active)
               state_d = hcp_pkg::HCP_IDLE;
         end
         default:
            state_d = hcp_pkg::HCP_IDLE;
      endcase
   end

   always_ff @(posedge CORE_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
         state_q <= hcp_pkg::HCP_IDLE;
      else
         state_q <= state_d;
   end

   always_ff @(posedge CORE_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
         rd_q <= 1'h0;
      else if (start)
         rd_q <= host_read;
   end

   // ram index uses the current cycle's own address bits only
   assign ram_addr = HOST_WORD_ADDR_I[RAM_AW:1]; // see [RL3]
   assign ram_re = start && host_read && host_ram && !host_hi; // see [RL5]
   assign ram_we = start && !host_read && host_ram && host_hi; // see [RL4]
   assign ram_wdata = {HOST_DATA_BUS_I, wr_cache_q}; // see [RL4] [RL8]

   hcp_ram #(.DW(32), .AW(RAM_AW)) u_ram (
      .clk_i(CORE_CLK_I),
      .rst_i(RESET_I),
      .re_i(ram_re),
      .we_i(ram_we),
      .addr_i(ram_addr),
      .wdata_i(ram_wdata),
      .rdata_o(ram_rdata)
   );

   // no ram access here; a second low-half write simply replaces the cache
   always_ff @(posedge CORE_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
         wr_cache_q <= 16'h0000;
      else if (start && !host_read && host_ram && !host_hi)
         wr_cache_q <= HOST_DATA_BUS_I; // see [RL4] [RL19]
   end

   always_ff @(posedge CORE_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
         rd_cache_q <= 16'h0000;
      else if (state_q == hcp_pkg::HCP_RD_WAIT)
         rd_cache_q <= ram_rdata[31:16]; // see [RL5]
   end

   // host view of the registers is the low 16 bits of each
   always_comb
   begin
      unique case (HOST_WORD_ADDR_I[2:0])
         hcp_pkg::HREG_VERSION: host_reg16 = version_word[15:0];
         hcp_pkg::HREG_MAIN_STATUS: host_reg16 = {8'h00, main_if.status};
         hcp_pkg::HREG_MAIN_MASK: host_reg16 = {8'h00, main_if.mask};
         hcp_pkg::HREG_TIMER_STATUS: host_reg16 = {8'h00, timer_if.status};
         hcp_pkg::HREG_TIMER_MASK: host_reg16 = {8'h00, timer_if.mask};
         default: host_reg16 = 16'h0000;
      endcase
   end

   always_ff @(posedge CORE_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
         data_o_q <= 16'h0000;
      else if (start && host_read)
      begin
         if (host_ram && host_hi)
            data_o_q <= rd_cache_q; // see [RL6]
         else if (!host_ram)
            data_o_q <= host_reg16; // see [RL1]
      end
      else if (state_q == hcp_pkg::HCP_RD_WAIT)
         data_o_q <= ram_rdata[15:0]; // see [RL5] [RL8]
   end

   // drive the bus only while a read is acknowledged
   always_ff @(posedge CORE_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         oe_q <= 1'h0;
         ack_q <= 1'h0;
      end
      else
      begin
         ack_q <= state_d == hcp_pkg::HCP_ACK; // see [RL9] [RL16]
         oe_q <= (state_d == hcp_pkg::HCP_ACK) && (start ? host_read : rd_q);
      end
   end

   assign version_word = {23'h000000, mode_q, REV_CODE}; // see [RL15]

   // ahb-lite slave: zero wait states, reads registered in the address phase
   assign ahb_valid = HSEL_I && HTRANS_I[1] && HREADY_I;

   always_comb
   begin
      unique case (HADDR_I[7:0])
         hcp_pkg::REG_VERSION: ahb_rd_mux = version_word;
         hcp_pkg::REG_MAIN_STATUS: ahb_rd_mux = {24'h000000, main_if.status};
         hcp_pkg::REG_MAIN_MASK: ahb_rd_mux = {24'h000000, main_if.mask};
         hcp_pkg::REG_TIMER_STATUS: ahb_rd_mux = {24'h000000, timer_if.status};
         hcp_pkg::REG_TIMER_MASK: ahb_rd_mux = {24'h000000, timer_if.mask};
         hcp_pkg::REG_CACHES: ahb_rd_mux = {rd_cache_q, wr_cache_q};
         default: ahb_rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge CORE_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         wr_pend_q <= 1'h0;
         wr_addr_q <= 8'h00;
      end
      else
      begin
         wr_pend_q <= ahb_valid && HWRITE_I && (HADDR_I[31:8] == 24'h000000);
         wr_addr_q <= HADDR_I[7:0];
      end
   end

   always_ff @(posedge CORE_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
         hrdata_q <= 32'h00000000;
      else if (ahb_valid && !HWRITE_I && (HADDR_I[31:8] == 24'h000000))
         hrdata_q <= ahb_rd_mux;
      else
         hrdata_q <= 32'h00000000;
   end

   always_ff @(posedge CORE_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         hreadyout_q <= 1'h1;
         hresp_q <= 1'h0;
      end
      else
      begin
         hreadyout_q <= 1'h1;
         hresp_q <= 1'h0;
      end
   end

   // interrupt banks; status bits clear by writing ones
   assign main_if.event_v = MAIN_EVENT_I;
   assign main_if.clr_v = (wr_pend_q && wr_addr_q == hcp_pkg::REG_MAIN_STATUS) ?
      HWDATA_I[7:0] : 8'h00;
   assign main_if.mask_we = wr_pend_q && wr_addr_q == hcp_pkg::REG_MAIN_MASK;
   assign main_if.mask_wdata = HWDATA_I[7:0];
   assign timer_if.event_v = TIMER_EXPIRE_I;
   assign timer_if.clr_v = (wr_pend_q && wr_addr_q == hcp_pkg::REG_TIMER_STATUS) ?
      HWDATA_I[7:0] : 8'h00;
   assign timer_if.mask_we = wr_pend_q && wr_addr_q == hcp_pkg::REG_TIMER_MASK;
   assign timer_if.mask_wdata = HWDATA_I[7:0];

   hcp_irq #(.W(8), .MASK_RST(hcp_pkg::MAIN_MASK_RST)) u_main_irq ( // see [RL10] [RL11]
      .clk_i(CORE_CLK_I),
      .rst_i(RESET_I),
      .b(main_if.bank)
   );

   hcp_irq #(.W(8), .MASK_RST(hcp_pkg::TIMER_MASK_RST)) u_timer_irq ( // see [RL10] [RL12]
      .clk_i(CORE_CLK_I),
      .rst_i(RESET_I),
      .b(timer_if.bank)
   );

   assign HRDATA_O = hrdata_q;
   assign HREADYOUT_O = hreadyout_q;
   assign HRESP_O = hresp_q;
   assign HOST_DATA_BUS_O = data_o_q;
   assign HOST_DATA_BUS_OE_O = oe_q;
   assign HOST_ACCESS_ACK_O = ack_q;
   assign MAIN_IRQ_OUT_O = main_if.irq;
   assign AUX_IRQ_OUT_O = timer_if.irq;

   a_mode_strap: // see [RL13]
   assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
      (!strap_done_q && !RESET_I)
      |=> (mode_q == ($past(BUS_STYLE_STRAP_A_I) && $past(BUS_STYLE_STRAP_B_I))))
   else $error("bus style not taken from straps");

   a_mode_frozen: // see [RL18]
   assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
      strap_done_q |=> $stable(mode_q))
   else $error("bus style changed after reset");

   a_version_mode: // see [RL15]
   assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
      (ahb_valid && !HWRITE_I && HADDR_I == 32'h00000000)
      |=> (hrdata_q[hcp_pkg::VER_MODE_POS] == mode_q))
   else $error("version register does not show bus style");

   a_wcache_only: // see [RL19]
   assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
      (start && !host_read && host_ram && !host_hi)
      |-> !ram_we ##1 (wr_cache_q == $past(HOST_DATA_BUS_I)))
   else $error("low-half write touched ram or missed cache");

   a_commit_word: // see [RL4]
   assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
      ram_we |-> (ram_wdata[31:16] == HOST_DATA_BUS_I) && (ram_wdata[15:0] == wr_cache_q))
   else $error("committed word not bus over cache");

   a_own_address: // see [RL3]
   assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
      ram_we |=> (u_ram.mem[$past(HOST_WORD_ADDR_I[RAM_AW:1])] == $past(ram_wdata)))
   else $error("ram word not written at the current address");

   a_low_fetch: // see [RL5]
   assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
      ram_re |=> (state_q == hcp_pkg::HCP_RD_WAIT) ##1
      ((data_o_q == $past(ram_rdata[15:0])) && (rd_cache_q == $past(ram_rdata[31:16]))))
   else $error("low-half read did not split the ram word");

   a_high_cache: // see [RL6]
   assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
      (start && host_read && host_ram && host_hi)
      |-> !ram_re ##1 (data_o_q == $past(rd_cache_q)) && ack_q)
   else $error("high-half read not served from read cache");

   a_ack_bound: // see [RL9]
   assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
      start |-> ##[1:ACK_MAX_CYC] ack_q)
   else $error("acknowledge late");

   a_oe_reads_only: // see [RL1]
   assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
      oe_q |-> ack_q && rd_q)
   else $error("data bus driven outside a read acknowledge");
endmodule : hcp_top

// ### tb/hcp_host_bfm.sv
// hcp_host_bfm: split or r/w style 16-bit host cpu on the host port of hcp_top.
// assumes: core clock shared with the device; the caller checks hung after each access.
`timescale 1ns/1ps
module hcp_host_bfm (
   // clock
   input wire logic clk_i,
   // host bus
   output logic [17:0] addr_o,
   output logic [15:0] data_o,
   input wire logic [15:0] data_i,
   output logic cs_n_o,
   output logic rd_n_o,
   output logic wr_n_o,
   input wire logic ack_i
);
   logic hung = 1'b0;
   // set by the bench: r/w style pins, and a host that ignores the acknowledge
   logic rw_style = 1'b0;
   logic blind = 1'b0;

   initial
   begin
      addr_o = 18'h00000;
      data_o = 16'h0000;
      cs_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
   end

   // one 16-bit transfer; a 32-bit word is two calls, low half first
   task automatic access(input logic w, input logic [17:0] a, input logic [15:0] d,
      output logic [15:0] q);
      int n;
      @(posedge clk_i);
      addr_o <= a;
      data_o <= w ? d : ~data_o;
      cs_n_o <= 1'b0;
      rd_n_o <= rw_style ? ~w : w;
      wr_n_o <= rw_style ? 1'b0 : ~w;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while ((blind ? n <= hcp_pkg::HOST_WAIT_STATES : ack_i !== 1'b1) && n < 50);
      q = data_i;
      hung = hung | (n >= 50);
      cs_n_o <= 1'b1;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      // released lanes show the inverse, so stale data never passes for an answer
      data_o <= ~data_o;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_i !== 1'b0 && n < 50);
      hung = hung | (n >= 50);
   endtask : access
endmodule : hcp_host_bfm

// ### tb/hcp_top_tb.sv
// hcp_top_tb: self-checking bench for hcp_top, ahb-lite register tasks plus a host cpu model.
// assumes: one 125 MHz clock; all inputs move by non-blocking assignment at rising edges.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
   $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module hcp_top_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hready;
   logic hresp;
   logic sa = 1'b0;
   logic sb = 1'b0;
   logic [7:0] main_ev = 8'h00;
   logic [7:0] tmr_ev = 8'h00;
   logic main_irq;
   logic aux_irq;
   logic [17:0] h_addr;
   logic [15:0] h_do;
   logic [15:0] dev_do;
   logic dev_oe;
   logic [15:0] h_bus;
   logic cs_n;
   logic rd_n;
   logic wr_n;
   logic ack;
   logic [31:0] r;
   logic [15:0] h;
   int failures = 0;
   int comparisons = 0;

   assign h_bus = dev_oe ? dev_do : h_do;

   hcp_top dut (
      .CORE_CLK_I(clk), .RESET_I(rst), .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans),
      .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
      .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
      .HOST_WORD_ADDR_I(h_addr), .HOST_DATA_BUS_I(h_bus), .HOST_DATA_BUS_O(dev_do),
      .HOST_DATA_BUS_OE_O(dev_oe), .HOST_CS_N_I(cs_n), .HOST_RD_N_I(rd_n),
      .HOST_WR_N_I(wr_n), .HOST_ACCESS_ACK_O(ack), .BUS_STYLE_STRAP_A_I(sa),
      .BUS_STYLE_STRAP_B_I(sb), .MAIN_EVENT_I(main_ev), .TIMER_EXPIRE_I(tmr_ev),
      .MAIN_IRQ_OUT_O(main_irq), .AUX_IRQ_OUT_O(aux_irq)
   );

   hcp_host_bfm host (
      .clk_i(clk), .addr_o(h_addr), .data_o(h_do), .data_i(h_bus),
      .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .ack_i(ack)
   );

   initial
   begin
      forever #4 clk = ~clk;
   end

   task tally_and_finish;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : tally_and_finish

   // straps settle with reset and stay put well past the three-clock hold
   task reset_dut(input logic a, input logic b);
      @(posedge clk);
      rst <= 1'b1;
      sa <= a;
      sb <= b;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : reset_dut

   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (hready !== 1'b1 && n < 20);
      htrans <= 2'h0;
      hwdata <= d;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (hready !== 1'b1 && n < 40);
      q = hrdata;
      `CHK(hresp, 1'b0)
      if (n >= 40)
      begin
         failures++;
         tally_and_finish;
      end
   endtask : ahb

   task hx(input logic w, input logic [17:0] a, input logic [15:0] d, output logic [15:0] q);
      host.access(w, a, d, q);
      if (host.hung)
      begin
         failures++;
         tally_and_finish;
      end
   endtask : hx

   task pulse(input logic m, input logic [7:0] v);
      @(posedge clk);
      if (m)
         main_ev <= v;
      else
         tmr_ev <= v;
      @(posedge clk);
      main_ev <= 8'h00;
      tmr_ev <= 8'h00;
      repeat (3) @(posedge clk);
   endtask : pulse

   initial
   begin
      for (int i = 3; i >= 0; i--)
      begin
         reset_dut(i[1], i[0]);
         ahb(1'b0, hcp_pkg::REG_VERSION, 32'h0, r);
         `CHK(r, {23'h0, i == 3, 8'h5a})
         if (i == 3)
         begin
            // r/w style pins: rd_n is the direction, wr_n the data strobe
            host.rw_style = 1'b1;
            hx(1'b1, 18'h00208, 16'h7777, h);
            hx(1'b1, 18'h00209, 16'h8888, h);
            hx(1'b0, 18'h00208, 16'h0, h);
            `CHK(h, 16'h7777)
            hx(1'b0, 18'h00209, 16'h0, h);
            `CHK(h, 16'h8888)
            hx(1'b0, 18'h00000, 16'h0, h);
            `CHK(h, 16'h015a)
            host.rw_style = 1'b0;
         end
      end
      ahb(1'b1, hcp_pkg::REG_VERSION, 32'hffffffff, r);
      ahb(1'b0, hcp_pkg::REG_VERSION, 32'h0, r);
      `CHK(r, 32'h0000005a)
      ahb(1'b1, 8'h40, 32'hffffffff, r);
      ahb(1'b0, 8'h40, 32'h0, r);
      `CHK(r, 32'h0)
      $display("test straps and version done");

      hx(1'b1, 18'h00200, 16'h1234, h);
      hx(1'b1, 18'h00201, 16'habcd, h);
      hx(1'b0, 18'h00200, 16'h0, h);
      `CHK(h, 16'h1234)
      hx(1'b0, 18'h00201, 16'h0, h);
      `CHK(h, 16'habcd)
      hx(1'b1, 18'h00202, 16'h1111, h);
      hx(1'b1, 18'h00202, 16'h2222, h);
      hx(1'b1, 18'h00203, 16'h3333, h);
      hx(1'b0, 18'h00202, 16'h0, h);
      `CHK(h, 16'h2222)
      ahb(1'b0, hcp_pkg::REG_CACHES, 32'h0, r);
      `CHK(r, 32'h33332222)
      hx(1'b1, 18'h00204, 16'h5555, h);
      hx(1'b1, 18'h00207, 16'h6666, h);
      hx(1'b0, 18'h00206, 16'h0, h);
      `CHK(h, 16'h5555)
      hx(1'b0, 18'h00207, 16'h0, h);
      `CHK(h, 16'h6666)
      hx(1'b0, 18'h00200, 16'h0, h);
      `CHK(h, 16'h1234)
      hx(1'b0, 18'h00203, 16'h0, h);
      `CHK(h, 16'habcd)
      // a host that ignores the acknowledge and just counts wait states
      host.blind = 1'b1;
      hx(1'b0, 18'h00200, 16'h0, h);
      `CHK(h, 16'h1234)
      host.blind = 1'b0;
      hx(1'b0, 18'h00000, 16'h0, h);
      `CHK(h, 16'h005a)
      hx(1'b0, 18'h00002, 16'h0, h);
      `CHK(h, 16'h00ff)
      $display("test host port done");

      pulse(1'b1, 8'h08);
      `CHK(main_irq, 1'b0)
      ahb(1'b0, hcp_pkg::REG_MAIN_STATUS, 32'h0, r);
      `CHK(r, 32'h08)
      ahb(1'b1, hcp_pkg::REG_MAIN_MASK, 32'hf7, r);
      repeat (3) @(posedge clk);
      `CHK(main_irq, 1'b1)
      `CHK(aux_irq, 1'b0)
      ahb(1'b1, hcp_pkg::REG_MAIN_STATUS, 32'h08, r);
      repeat (3) @(posedge clk);
      `CHK(main_irq, 1'b0)
      for (int i = 0; i < 8; i++)
      begin
         pulse(1'b0, 8'h01 << i);
         `CHK(aux_irq, 1'b1)
         ahb(1'b0, hcp_pkg::REG_TIMER_STATUS, 32'h0, r);
         `CHK(r, {24'h0, 8'h01 << i})
         ahb(1'b1, hcp_pkg::REG_TIMER_STATUS, {24'h0, 8'h01 << i}, r);
         repeat (3) @(posedge clk);
         `CHK(aux_irq, 1'b0)
      end
      ahb(1'b1, hcp_pkg::REG_TIMER_MASK, 32'hff, r);
      pulse(1'b0, 8'h80);
      `CHK(aux_irq, 1'b0)
      ahb(1'b0, hcp_pkg::REG_TIMER_STATUS, 32'h0, r);
      `CHK(r, 32'h80)
      $display("test interrupts done");
      tally_and_finish;
   end
endmodule : hcp_top_tb
